/* verilog/temp_alarm_pkg.sv */
// Shared constants and types for the temperature alarm configuration and status block
package temp_alarm_pkg;

  // ----------------------------------------------------------------
  // Register command indices
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_SETUP = 8'h41;
  localparam logic [7:0] REG_WMASK = 8'h42;
  localparam logic [7:0] REG_OMASK = 8'h43;
  localparam logic [7:0] REG_HIFLAGS = 8'h44;
  localparam logic [7:0] REG_OVHFLAGS = 8'h45;
  localparam logic [7:0] REG_FAULT = 8'h46;
  localparam logic [7:0] REG_LOFLAGS = 8'h47;
  localparam logic [7:0] UNMAPPED_DATA = 8'h00;

  // ----------------------------------------------------------------
  // Setup register fields and reset values
  // ----------------------------------------------------------------
  localparam int STANDBY_BIT = 7;
  localparam int SOFT_RST_BIT = 6;
  localparam int TIMEOUT_DIS_BIT = 5;
  localparam int WIDE_RANGE_BIT = 1;
  localparam logic [7:0] SETUP_STORE_MASK = 8'hA2;
  localparam logic [7:0] SETUP_RST = 8'h00;
  localparam logic [7:0] MASK_RST = 8'h00;
  localparam logic [7:0] FLAGS_RST = 8'h00;

  // ----------------------------------------------------------------
  // Bus addressing, thresholds and timing
  // ----------------------------------------------------------------
  localparam logic [6:0] ARA_ADDR = 7'h0C;
  localparam logic [7:0] OVH_HYST = 8'h04;
  localparam int CHANNELS = 8;
  localparam int CLK_HZ = 40000000;
  localparam int BUS_TIMEOUT_US = 25000;
  localparam int TIMEOUT_CYCLES = (CLK_HZ / 1000000) * BUS_TIMEOUT_US;

  // ----------------------------------------------------------------
  // Serial slave states, Gray coded along the write path
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    BUS_IDLE = 4'h0,
    BUS_ADDR = 4'h1,
    BUS_ADDR_ACK = 4'h3,
    BUS_CMD = 4'h2,
    BUS_CMD_ACK = 4'h6,
    BUS_WDATA = 4'h7,
    BUS_WDATA_ACK = 4'h5,
    BUS_RDATA = 4'h4,
    BUS_RDATA_ACK = 4'hC
  } bus_state_e;

endpackage : temp_alarm_pkg

/* verilog/overheat_channel.sv */
// One channel of overheat status with hysteresis on release
`timescale 1ns/1ps
`default_nettype none

module overheat_channel #(
  parameter int TEMP_W = 8
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_i,
  // Conversion result of this channel
  input wire logic eoc_i,
  input wire logic [TEMP_W-1:0] temp_i,
  input wire logic [TEMP_W-1:0] limit_i,
  // Sticky overheat flag
  output logic flag_o
);

  // ----------------------------------------------------------------
  // Set and release conditions
  // ----------------------------------------------------------------
  if (TEMP_W < 4) begin : g_bad_width
    $error("overheat_channel: TEMP_W too small for hysteresis");
  end

  logic trip;
  logic release_ok;
  // Extra bit keeps temp plus hysteresis from wrapping
  assign trip = eoc_i && (temp_i > limit_i);
  assign release_ok = ({1'b0, temp_i} + {1'b0, TEMP_W'(temp_alarm_pkg::OVH_HYST)})
                      <= {1'b0, limit_i};

  // Flag holds until temp is 4 degrees under the limit or limit moved up
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      flag_o <= 1'b0;
    end else if (trip) begin
      flag_o <= 1'b1;
    end else if (release_ok) begin
      flag_o <= 1'b0;
    end
  end

endmodule : overheat_channel

`default_nettype wire

/* verilog/temp_alarm_config_status.sv */
// Setup, alarm masks, alarm status and serial register access of the temperature monitor
`timescale 1ns/1ps
`default_nettype none

module temp_alarm_config_status #(
  parameter logic [6:0] SLAVE_ADDR = 7'h4C, // Arbitrary value, set per board
  parameter int TIMEOUT_CYCLES = temp_alarm_pkg::TIMEOUT_CYCLES
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic sys_rst_i,
  // Serial bus pins, open drain data
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  // Conversion engine results, bit 7 ch7, bit 6 local, bits 5..0 ch6..ch1
  input wire logic [7:0] eoc_i,
  input wire logic [7:0] hi_cmp_i,
  input wire logic [7:0] lo_cmp_i,
  input wire logic [7:0] diode_fault_i,
  input wire logic [63:0] temp_i,
  input wire logic [63:0] ovh_limit_i,
  // Controls to the conversion engine
  output logic conv_run_o,
  output logic wide_range_en_o,
  output logic soft_reset_o,
  // Open-drain alarm pins
  output logic warn_o,
  output logic warn_oe_o,
  output logic ovh_o,
  output logic ovh_oe_o
);

  // ----------------------------------------------------------------
  // Elaboration checks and declarations
  // ----------------------------------------------------------------
  if (TIMEOUT_CYCLES < 2 || TIMEOUT_CYCLES > 16777215) begin : g_bad_timeout
    $error("temp_alarm_config_status: TIMEOUT_CYCLES out of range");
  end

  localparam int TO_W = $clog2(TIMEOUT_CYCLES + 1);
  localparam logic [TO_W-1:0] TO_LAST = TO_W'(TIMEOUT_CYCLES - 1);

  temp_alarm_pkg::bus_state_e state;
  logic scl_m, scl_s, scl_d, sda_m, sda_s, sda_d;
  logic scl_rise, scl_fall, start_seen, stop_seen, timeout_hit;
  logic [3:0] bitcnt;
  logic [7:0] shreg, tx, ptr, rd_data, next_byte;
  logic is_read, ara_mode, wr_stb, rd_done, ara_done;
  logic [TO_W-1:0] to_cnt;
  logic soft_rst, reg_rst, warn_latch;
  logic [7:0] setup, wmask, omask, hi_flags, lo_flags, ovh_flags, pend_w;
  logic [6:0] fault_flags, fault_eoc, fault_val;
  logic setup_wr;

  // ----------------------------------------------------------------
  // Pin synchronisers and bus event detection
  // ----------------------------------------------------------------
  // Three flops per pin; edges are found only past the second stage
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      {scl_m, scl_s, scl_d} <= 3'h7;
      {sda_m, sda_s, sda_d} <= 3'h7;
    end else begin
      {scl_m, scl_s, scl_d} <= {scl_i, scl_m, scl_s};
      {sda_m, sda_s, sda_d} <= {sda_i, sda_m, sda_s};
    end
  end

  assign scl_rise = scl_s && !scl_d;
  assign scl_fall = !scl_s && scl_d;
  assign start_seen = scl_s && scl_d && sda_d && !sda_s;
  assign stop_seen = scl_s && scl_d && !sda_d && sda_s;
  assign timeout_hit = (to_cnt == TO_LAST);

  // Counts clock-low time inside a frame; cleared when disabled
  always_ff @(posedge clock_i) begin
    if (sys_rst_i || state == temp_alarm_pkg::BUS_IDLE || scl_s
        || setup[temp_alarm_pkg::TIMEOUT_DIS_BIT]) begin
      to_cnt <= '0;
    end else if (!timeout_hit) begin
      to_cnt <= to_cnt + TO_W'(1);
    end
  end

  // ----------------------------------------------------------------
  // Serial slave: write byte, read byte, send byte, receive byte
  // ----------------------------------------------------------------
  // Alert response answers with our address, lowest bit zero
  assign next_byte = ara_mode ? {SLAVE_ADDR, 1'b0} : rd_data;

  // Runs on sys reset only, so a soft reset cannot cut its own ack
  always_ff @(posedge clock_i) begin
    wr_stb <= 1'b0;
    rd_done <= 1'b0;
    ara_done <= 1'b0;
    if (sys_rst_i) begin
      state <= temp_alarm_pkg::BUS_IDLE;
      bitcnt <= 4'h0;
      shreg <= 8'h00;
      tx <= 8'h00;
      ptr <= 8'h00;
      is_read <= 1'b0;
      ara_mode <= 1'b0;
      sda_oe_o <= 1'b0;
    end else if (stop_seen || timeout_hit) begin
      state <= temp_alarm_pkg::BUS_IDLE;
      sda_oe_o <= 1'b0;
    end else if (start_seen) begin
      state <= temp_alarm_pkg::BUS_ADDR;
      bitcnt <= 4'h0;
      sda_oe_o <= 1'b0;
    end else if (scl_rise) begin
      unique case (state)
        temp_alarm_pkg::BUS_ADDR, temp_alarm_pkg::BUS_CMD, temp_alarm_pkg::BUS_WDATA: begin
          shreg <= {shreg[6:0], sda_s};
          bitcnt <= bitcnt + 4'h1;
        end
        temp_alarm_pkg::BUS_RDATA: begin
          bitcnt <= bitcnt + 4'h1;
          // Released a one but line is low: arbitration lost
          if (!sda_oe_o && !sda_s) begin
            state <= temp_alarm_pkg::BUS_IDLE;
          end
        end
        temp_alarm_pkg::BUS_RDATA_ACK: begin
          if (sda_s) begin
            state <= temp_alarm_pkg::BUS_IDLE;
          end
        end
        default: begin
        end
      endcase
    end else if (scl_fall) begin
      unique case (state)
        temp_alarm_pkg::BUS_IDLE: begin
        end
        temp_alarm_pkg::BUS_ADDR: begin
          if (bitcnt == 4'h8) begin
            if (shreg[7:1] == SLAVE_ADDR) begin
              state <= temp_alarm_pkg::BUS_ADDR_ACK;
              sda_oe_o <= 1'b1;
              is_read <= shreg[0];
              ara_mode <= 1'b0;
            end else if (shreg[7:1] == temp_alarm_pkg::ARA_ADDR && shreg[0] && warn_latch) begin
              state <= temp_alarm_pkg::BUS_ADDR_ACK;
              sda_oe_o <= 1'b1;
              is_read <= 1'b1;
              ara_mode <= 1'b1;
            end else begin
              state <= temp_alarm_pkg::BUS_IDLE;
            end
          end
        end
        temp_alarm_pkg::BUS_ADDR_ACK, temp_alarm_pkg::BUS_RDATA_ACK: begin
          if (state == temp_alarm_pkg::BUS_RDATA_ACK || is_read) begin
            state <= temp_alarm_pkg::BUS_RDATA;
            sda_oe_o <= !next_byte[7];
            tx <= {next_byte[6:0], 1'b0};
          end else begin
            state <= temp_alarm_pkg::BUS_CMD;
            sda_oe_o <= 1'b0;
          end
          bitcnt <= 4'h0;
        end
        temp_alarm_pkg::BUS_CMD: begin
          if (bitcnt == 4'h8) begin
            ptr <= shreg;
            state <= temp_alarm_pkg::BUS_CMD_ACK;
            sda_oe_o <= 1'b1;
          end
        end
        temp_alarm_pkg::BUS_CMD_ACK, temp_alarm_pkg::BUS_WDATA_ACK: begin
          state <= temp_alarm_pkg::BUS_WDATA;
          sda_oe_o <= 1'b0;
          bitcnt <= 4'h0;
        end
        temp_alarm_pkg::BUS_WDATA: begin
          if (bitcnt == 4'h8) begin
            wr_stb <= 1'b1;
            state <= temp_alarm_pkg::BUS_WDATA_ACK;
            sda_oe_o <= 1'b1;
          end
        end
        temp_alarm_pkg::BUS_RDATA: begin
          if (bitcnt == 4'h8) begin
            state <= temp_alarm_pkg::BUS_RDATA_ACK;
            sda_oe_o <= 1'b0;
            rd_done <= !ara_mode;
            ara_done <= ara_mode;
          end else begin
            sda_oe_o <= !tx[7];
            tx <= {tx[6:0], 1'b0};
          end
        end
        default: begin
          state <= temp_alarm_pkg::BUS_IDLE;
        end
      endcase
    end
  end

  assign sda_o = 1'b0;

  // ----------------------------------------------------------------
  // Setup and mask registers
  // ----------------------------------------------------------------
  assign setup_wr = wr_stb && ptr == temp_alarm_pkg::REG_SETUP;
  assign reg_rst = sys_rst_i || soft_rst;

  // Self-clearing soft reset; one cycle, never stored
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      soft_rst <= 1'b0;
    end else begin
      soft_rst <= setup_wr && shreg[temp_alarm_pkg::SOFT_RST_BIT];
    end
  end

  // Reserved bits are not stored, so they read zero whatever the host sends
  always_ff @(posedge clock_i) begin
    if (reg_rst) begin
      setup <= temp_alarm_pkg::SETUP_RST;
    end else if (setup_wr) begin
      setup <= shreg & temp_alarm_pkg::SETUP_STORE_MASK;
    end
  end

  // Alarm masks
  always_ff @(posedge clock_i) begin
    if (reg_rst) begin
      wmask <= temp_alarm_pkg::MASK_RST;
      omask <= temp_alarm_pkg::MASK_RST;
    end else if (wr_stb) begin
      if (ptr == temp_alarm_pkg::REG_WMASK) begin
        wmask <= shreg;
      end
      if (ptr == temp_alarm_pkg::REG_OMASK) begin
        omask <= shreg;
      end
    end
  end

  assign conv_run_o = !setup[temp_alarm_pkg::STANDBY_BIT];
  assign wide_range_en_o = setup[temp_alarm_pkg::WIDE_RANGE_BIT];
  assign soft_reset_o = soft_rst;

  // ----------------------------------------------------------------
  // Status flags
  // ----------------------------------------------------------------
  // Sticky warning flags; a new event wins over a clearing read
  always_ff @(posedge clock_i) begin
    if (reg_rst) begin
      hi_flags <= temp_alarm_pkg::FLAGS_RST;
      lo_flags <= temp_alarm_pkg::FLAGS_RST;
    end else begin
      hi_flags <= ((rd_done && ptr == temp_alarm_pkg::REG_HIFLAGS) ? 8'h00 : hi_flags)
                  | (eoc_i & hi_cmp_i);
      lo_flags <= ((rd_done && ptr == temp_alarm_pkg::REG_LOFLAGS) ? 8'h00 : lo_flags)
                  | (eoc_i & lo_cmp_i);
    end
  end

  // Diode faults follow each remote conversion; local slot has no diode
  assign fault_eoc = {eoc_i[7], eoc_i[5:0]};
  assign fault_val = {diode_fault_i[7], diode_fault_i[5:0]};
  always_ff @(posedge clock_i) begin
    if (reg_rst) begin
      fault_flags <= 7'h00;
    end else begin
      fault_flags <= (fault_flags & ~fault_eoc) | (fault_val & fault_eoc);
    end
  end

  // One overheat tracker per channel
  for (genvar i = 0; i < temp_alarm_pkg::CHANNELS; i++) begin : g_ovh
    overheat_channel #(
      .TEMP_W(8)
    ) u_ovh (
      .clock_i(clock_i),
      .rst_i(reg_rst),
      .eoc_i(eoc_i[i]),
      .temp_i(temp_i[8*i +: 8]),
      .limit_i(ovh_limit_i[8*i +: 8]),
      .flag_o(ovh_flags[i])
    );
  end

  // ----------------------------------------------------------------
  // Register read mux
  // ----------------------------------------------------------------
  always_comb begin
    case (ptr)
      temp_alarm_pkg::REG_SETUP: rd_data = setup;
      temp_alarm_pkg::REG_WMASK: rd_data = wmask;
      temp_alarm_pkg::REG_OMASK: rd_data = omask;
      temp_alarm_pkg::REG_HIFLAGS: rd_data = hi_flags;
      temp_alarm_pkg::REG_OVHFLAGS: rd_data = ovh_flags;
      temp_alarm_pkg::REG_FAULT: rd_data = {1'b0, fault_flags};
      temp_alarm_pkg::REG_LOFLAGS: rd_data = lo_flags;
      default: rd_data = temp_alarm_pkg::UNMAPPED_DATA;
    endcase
  end

  // ----------------------------------------------------------------
  // Alarm outputs
  // ----------------------------------------------------------------
  assign pend_w = (hi_flags | lo_flags) & ~wmask;

  // Latch re-arms only at a conversion end, so a high-flag read or alert response keeps it quiet until then
  always_ff @(posedge clock_i) begin
    if (reg_rst) begin
      warn_latch <= 1'b0;
    end else if ((eoc_i & (hi_cmp_i | lo_cmp_i) & ~wmask) != 8'h00) begin
      warn_latch <= 1'b1;
    end else if ((rd_done && ptr == temp_alarm_pkg::REG_HIFLAGS) || ara_done) begin
      warn_latch <= 1'b0;
    end
  end

  // Registered pin enables, pulled low while active
  always_ff @(posedge clock_i) begin
    if (reg_rst) begin
      warn_oe_o <= 1'b0;
      ovh_oe_o <= 1'b0;
    end else begin
      warn_oe_o <= warn_latch && (pend_w != 8'h00);
      ovh_oe_o <= (ovh_flags & ~omask) != 8'h00;
    end
  end

  assign warn_o = 1'b0;
  assign ovh_o = 1'b0;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  sequence s_hi_read;
    rd_done && ptr == temp_alarm_pkg::REG_HIFLAGS && eoc_i == 8'h00;
  endsequence
  sequence s_setup_write;
    setup_wr;
  endsequence

  property p_standby;
    @(posedge clock_i) disable iff (sys_rst_i)
    s_setup_write ##0 (shreg[7] && !shreg[6]) |=> !conv_run_o [*2];
  endproperty
  a_standby: assert property (p_standby) else $error("standby not entered");

  property p_soft_reset;
    @(posedge clock_i) disable iff (sys_rst_i)
    s_setup_write ##0 shreg[6] |=> soft_rst ##1 (!soft_rst && setup == 8'h00 && wmask == 8'h00);
  endproperty
  a_soft_reset: assert property (p_soft_reset) else $error("soft reset failed");

  property p_timeout;
    @(posedge clock_i) disable iff (sys_rst_i)
    (timeout_hit |=> state == temp_alarm_pkg::BUS_IDLE && !sda_oe_o)
    and (setup[5] |=> to_cnt == '0);
  endproperty
  a_timeout: assert property (p_timeout) else $error("bus timeout wrong");

  property p_range;
    @(posedge clock_i) disable iff (sys_rst_i)
    s_setup_write ##0 !shreg[6] |=> wide_range_en_o == $past(shreg[1]);
  endproperty
  a_range: assert property (p_range) else $error("range bit not applied");

  property p_warn_mask;
    @(posedge clock_i) disable iff (reg_rst)
    warn_oe_o |-> $past(pend_w != 8'h00);
  endproperty
  a_warn_mask: assert property (p_warn_mask) else $error("masked warning drove pin");

  property p_ovh_out;
    @(posedge clock_i) disable iff (reg_rst)
    ((ovh_flags & ~omask) != 8'h00) |=> ovh_oe_o;
  endproperty
  a_ovh_out: assert property (p_ovh_out) else $error("overheat pin not driven");

  property p_hi_set;
    @(posedge clock_i) disable iff (reg_rst)
    (eoc_i & hi_cmp_i) != 8'h00 |=> (hi_flags & $past(eoc_i & hi_cmp_i)) == $past(eoc_i & hi_cmp_i);
  endproperty
  a_hi_set: assert property (p_hi_set) else $error("high flag not set");

  property p_ovh_set;
    @(posedge clock_i) disable iff (reg_rst)
    eoc_i[0] && temp_i[7:0] > ovh_limit_i[7:0] |=> ovh_flags[0];
  endproperty
  a_ovh_set: assert property (p_ovh_set) else $error("overheat flag not set");

  property p_fault;
    @(posedge clock_i) disable iff (reg_rst)
    eoc_i[0] |=> fault_flags[0] == $past(diode_fault_i[0]);
  endproperty
  a_fault: assert property (p_fault) else $error("diode fault not recorded");

  property p_lo_set;
    @(posedge clock_i) disable iff (reg_rst)
    eoc_i[7] && lo_cmp_i[7] |=> lo_flags[7] ##1 (lo_flags[7] || $past(rd_done));
  endproperty
  a_lo_set: assert property (p_lo_set) else $error("low flag not held");

  property p_read_clear;
    @(posedge clock_i) disable iff (reg_rst)
    s_hi_read |=> hi_flags == 8'h00;
  endproperty
  a_read_clear: assert property (p_read_clear) else $error("read did not clear");

  property p_warn_release;
    @(posedge clock_i) disable iff (reg_rst)
    (s_hi_read or (ara_done && eoc_i == 8'h00)) |-> ##2 !warn_oe_o;
  endproperty
  a_warn_release: assert property (p_warn_release) else $error("warning not released");

  property p_ovh_hold;
    @(posedge clock_i) disable iff (reg_rst)
    $fell(ovh_flags[0]) && !$past(soft_rst)
    |-> $past({1'b0, temp_i[7:0]} + 9'h004 <= {1'b0, ovh_limit_i[7:0]});
  endproperty
  a_ovh_hold: assert property (p_ovh_hold) else $error("overheat released early");

  property p_ovh_reset;
    @(posedge clock_i) disable iff (sys_rst_i)
    $past(soft_rst) |-> ovh_flags == 8'h00 && hi_flags == 8'h00;
  endproperty
  a_ovh_reset: assert property (p_ovh_reset) else $error("flags not reset");

endmodule : temp_alarm_config_status

`default_nettype wire

/* verification/smbus_host_model.sv */
// Behavioural serial host that drives the register bus of the alarm block
`timescale 1ns/1ps
`default_nettype none

module smbus_host_model #(
  parameter logic [6:0] ADDR = 7'h2A // Arbitrary value
) (
  // Wired data line level
  input wire logic sda_i,
  // Bus clock and data pull-down
  output logic scl_o,
  output logic sda_low_o
);
  // ----------------------------------------------------------------
  // Bit, byte and frame tasks
  // ----------------------------------------------------------------
  int nacks = 0;
  initial begin
    scl_o = 1'b1;
    sda_low_o = 1'b0;
  end
  // Data moves mid low phase; low phase kept at six clocks
  task automatic bit_io(input logic b, output logic r);
    #75 sda_low_o = ~b;
    #75 scl_o = 1'b1;
    #25 r = sda_i;
    #25 scl_o = 1'b0;
  endtask : bit_io
  task automatic start_c();
    #75 sda_low_o = 1'b0;
    #75 scl_o = 1'b1;
    #100 sda_low_o = 1'b1;
    #100 scl_o = 1'b0;
  endtask : start_c
  // Clock stands high after the frame
  task automatic stop_c();
    #75 sda_low_o = 1'b1;
    #75 scl_o = 1'b1;
    #100 sda_low_o = 1'b0;
    #200;
  endtask : stop_c
  // Ninth bit always released; a missing device ack is counted
  task automatic byte_io(input logic [7:0] d, input logic chk_ack, output logic [7:0] r);
    logic a;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r[i]);
    bit_io(1'b1, a);
    if (chk_ack && a) nacks++;
  endtask : byte_io
  task automatic write_reg(input logic [7:0] cmd, input logic [7:0] d);
    logic [7:0] r;
    if (cmd == temp_alarm_pkg::REG_SETUP) d = d & 8'hE2; // Reserved bits zero
    start_c();
    byte_io({ADDR, 1'b0}, 1'b1, r);
    byte_io(cmd, 1'b1, r);
    byte_io(d, 1'b1, r);
    stop_c();
  endtask : write_reg
  task automatic read_reg(input logic [7:0] cmd, output logic [7:0] d);
    logic [7:0] r;
    start_c();
    byte_io({ADDR, 1'b0}, 1'b1, r);
    byte_io(cmd, 1'b1, r);
    start_c();
    byte_io({ADDR, 1'b1}, 1'b1, r);
    byte_io(8'hFF, 1'b0, d);
    stop_c();
  endtask : read_reg
  task automatic ara(output logic [7:0] d);
    logic [7:0] r;
    start_c();
    byte_io({temp_alarm_pkg::ARA_ADDR, 1'b1}, 1'b1, r); // Receive byte to 19h
    byte_io(8'hFF, 1'b0, d);
    stop_c();
  endtask : ara
endmodule : smbus_host_model

`default_nettype wire

/* verification/tb_temp_alarm_config_status.sv */
// Self-checking testbench for the alarm configuration and status block
`timescale 1ns/1ps
`default_nettype none

module tb_temp_alarm_config_status;
  // ----------------------------------------------------------------
  // Signals, instances and helpers
  // ----------------------------------------------------------------
  localparam logic [6:0] ADDR = 7'h2A; // Arbitrary value
  logic clock_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic [7:0] eoc = 8'h00, hi = 8'h00, lo = 8'h00, df = 8'h00, rd;
  logic [63:0] temp = '0, lim = '0;
  logic scl, sda_low, sda_o, sda_oe, run, wide, srst, warn, warn_oe, ovh, ovh_oe;
  wire logic sda;
  int n_errors = 0, cmp_count = 0;
  // Open-drain wire with pull-up
  assign sda = (sda_oe ? sda_o : 1'b1) & ~sda_low;
  always #12.5 clock_i = ~clock_i;
  smbus_host_model #(.ADDR(ADDR)) smbus_host_model_inst (.sda_i(sda), .scl_o(scl),
    .sda_low_o(sda_low));
  temp_alarm_config_status #(.SLAVE_ADDR(ADDR), .TIMEOUT_CYCLES(200))
    temp_alarm_config_status_inst (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .scl_i(scl),
    .sda_i(sda), .sda_o(sda_o), .sda_oe_o(sda_oe), .eoc_i(eoc), .hi_cmp_i(hi), .lo_cmp_i(lo),
    .diode_fault_i(df), .temp_i(temp), .ovh_limit_i(lim), .conv_run_o(run),
    .wide_range_en_o(wide), .soft_reset_o(srst), .warn_o(warn), .warn_oe_o(warn_oe),
    .ovh_o(ovh), .ovh_oe_o(ovh_oe));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic rchk(input logic [7:0] cmd, input logic [7:0] exp);
    smbus_host_model_inst.read_reg(cmd, rd);
    chk(rd, exp);
  endtask : rchk
  task automatic wr(input logic [7:0] cmd, input logic [7:0] d);
    smbus_host_model_inst.write_reg(cmd, d);
  endtask : wr
  // One-cycle conversion strobe, then let flags and pins settle
  task automatic conv(input logic [7:0] ch, input logic [7:0] h, input logic [7:0] l,
      input logic [7:0] d);
    @(posedge clock_i);
    #2 {eoc, hi, lo, df} = {ch, h, l, d};
    @(posedge clock_i);
    #2 eoc = 8'h00;
    repeat (4) @(posedge clock_i);
    #2;
  endtask : conv
  task automatic set_temp(input logic [7:0] t);
    @(posedge clock_i);
    #2 temp[7:0] = t;
    repeat (4) @(posedge clock_i);
    #2;
  endtask : set_temp
  // Clock held low after the address byte; the ack must drop only if the timeout is on
  task automatic hang(input logic [7:0] cfg, input logic [7:0] exp);
    logic r;
    logic [7:0] aw;
    aw = {ADDR, 1'b0};
    wr(temp_alarm_pkg::REG_SETUP, cfg);
    smbus_host_model_inst.start_c();
    for (int i = 7; i >= 0; i--) smbus_host_model_inst.bit_io(aw[i], r);
    repeat (20) @(posedge clock_i);
    #2 chk(sda_oe, 8'h01);
    repeat (250) @(posedge clock_i);
    #2 chk(sda_oe, exp);
    smbus_host_model_inst.stop_c();
  endtask : hang
  task automatic report_and_stop();
    $display("comparisons=%0d mismatches=%0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : report_and_stop
  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial begin
    lim[7:0] = 8'd90;
    repeat (5) @(posedge clock_i);
    #2 sys_rst_i = 1'b0;
    repeat (6) @(posedge clock_i);
    #2;
    chk(run, 1'b1);
    for (int a = 8'h41; a <= 8'h47; a++) rchk(8'(a), 8'h00);
    rchk(8'h50, temp_alarm_pkg::UNMAPPED_DATA);
    $display("test reset done");
    wr(temp_alarm_pkg::REG_SETUP, 8'hA2);
    rchk(temp_alarm_pkg::REG_SETUP, 8'hA2);
    chk(run, 1'b0);
    chk(wide, 1'b1);
    wr(temp_alarm_pkg::REG_SETUP, 8'h20);
    rchk(temp_alarm_pkg::REG_SETUP, 8'h20);
    chk({run, wide}, 8'h02);
    $display("test setup done");
    conv(8'h01, 8'h01, 8'h00, 8'h00);
    chk(warn_oe, 1'b1);
    rchk(temp_alarm_pkg::REG_HIFLAGS, 8'h01);
    chk(warn_oe, 1'b0);
    rchk(temp_alarm_pkg::REG_HIFLAGS, 8'h00);
    conv(8'h40, 8'h40, 8'h00, 8'h00);
    chk(warn_oe, 1'b1);
    smbus_host_model_inst.ara(rd);
    chk(rd, {ADDR, 1'b0});
    chk(warn_oe, 1'b0);
    rchk(temp_alarm_pkg::REG_HIFLAGS, 8'h40);
    conv(8'h80, 8'h00, 8'h80, 8'h00);
    chk(warn_oe, 1'b1);
    rchk(temp_alarm_pkg::REG_LOFLAGS, 8'h80);
    rchk(temp_alarm_pkg::REG_LOFLAGS, 8'h00);
    conv(8'h81, 8'h00, 8'h00, 8'h81);
    rchk(temp_alarm_pkg::REG_FAULT, 8'h41);
    wr(temp_alarm_pkg::REG_WMASK, 8'h01);
    rchk(temp_alarm_pkg::REG_WMASK, 8'h01);
    conv(8'h01, 8'h01, 8'h00, 8'h00);
    chk(warn_oe, 1'b0);
    rchk(temp_alarm_pkg::REG_HIFLAGS, 8'h01);
    $display("test warning done");
    set_temp(8'd100);
    conv(8'h01, 8'h00, 8'h00, 8'h00);
    chk(ovh_oe, 1'b1);
    rchk(temp_alarm_pkg::REG_OVHFLAGS, 8'h01);
    set_temp(8'd87);
    rchk(temp_alarm_pkg::REG_OVHFLAGS, 8'h01);
    set_temp(8'd86);
    chk(ovh_oe, 1'b0);
    rchk(temp_alarm_pkg::REG_OVHFLAGS, 8'h00);
    wr(temp_alarm_pkg::REG_OMASK, 8'h01);
    rchk(temp_alarm_pkg::REG_OMASK, 8'h01);
    set_temp(8'd100);
    conv(8'h01, 8'h00, 8'h00, 8'h00);
    chk(ovh_oe, 1'b0);
    rchk(temp_alarm_pkg::REG_OVHFLAGS, 8'h01);
    $display("test overheat done");
    wr(temp_alarm_pkg::REG_SETUP, 8'h40);
    rchk(temp_alarm_pkg::REG_SETUP, 8'h00);
    rchk(temp_alarm_pkg::REG_WMASK, 8'h00);
    rchk(temp_alarm_pkg::REG_OMASK, 8'h00);
    rchk(temp_alarm_pkg::REG_HIFLAGS, 8'h00);
    chk(8'(smbus_host_model_inst.nacks), 8'h00);
    $display("test soft reset done");
    hang(8'h00, 8'h00);
    hang(8'h20, 8'h01);
    $display("test timeout done");
    report_and_stop();
  end
  // Watchdog well beyond the expected run of about 300 us
  initial begin
    #2000000;
    n_errors++;
    report_and_stop();
  end
endmodule : tb_temp_alarm_config_status

`default_nettype wire
